/* design/tx_clock_pkg.sv */
// constants for the quad transmit clock selection block
package tx_clock_pkg;

  // channel count, register port widths and divider half-period width
  localparam int          NUM_CH         = 4;
  localparam int          ADDR_W         = 4;
  localparam int          DATA_W         = 16;
  localparam int          HALF_W         = 15;

  // register indices on the plain register port
  localparam logic [3:0]  TX_CLOCK_CONFIG_ADDR  = 4'h0;
  localparam logic [3:0]  CLOCK_OUT_CONFIG_ADDR = 4'h1;
  localparam logic [3:0]  CLOCK_STATUS_ADDR     = 4'h2;

  // tx_clock_config_reg fields
  localparam int          SRC_SEL_LSB    = 0;  // 2 bits per channel, bits 7:0
  localparam int          SRC_SEL_W      = 2;
  localparam int          LOOPBACK_LSB   = 8;  // one bit per channel, bits 11:8
  localparam int          TRISTATE_BIT   = 12; // 1 floats the differential clocks

  // clock_output_config_reg fields
  localparam int          RATE_LSB       = 0;  // 3 bits per channel, bits 11:0
  localparam int          RATE_W         = 3;
  localparam int          OC1_MODE_LSB   = 12; // 1 = 51 Mbit/s channel, bits 15:12

  // status register fields
  localparam int          EFF_SRC_LSB    = 0;  // effective source, 2 bits per channel
  localparam int          LB_STAT_LSB    = 8;  // loopback active per channel

  // reset values: every channel on its own clock input, clocks driven
  localparam logic [15:0] TX_CLOCK_CONFIG_RST  = 16'h00aa;
  localparam logic [15:0] CLOCK_OUT_CONFIG_RST = 16'h0000;

  // transmit clock source codes
  localparam logic [1:0]  SRC_RESERVED   = 2'h0;
  localparam logic [1:0]  SRC_RX_CLOCK   = 2'h1;
  localparam logic [1:0]  SRC_OWN_CLOCK  = 2'h2;
  localparam logic [1:0]  SRC_SHARED     = 2'h3;

  // rate codes of the single-ended output
  localparam logic [2:0]  RATE_CODE_0    = 3'h0;
  localparam logic [2:0]  RATE_CODE_1    = 3'h1;
  localparam logic [2:0]  RATE_CODE_2    = 3'h2;
  localparam logic [2:0]  RATE_CODE_3    = 3'h3;

  // half periods in transmit clock rising edges for the binary divisions
  localparam logic [14:0] HALF_DIV2      = 15'h0001;
  localparam logic [14:0] HALF_DIV4      = 15'h0002;
  localparam logic [14:0] HALF_DIV8      = 15'h0004;

  // 8 kHz frame clock divisors (155.52 MHz / 8 kHz and 51.84 MHz / 8 kHz)
  localparam int          OC3_FRAME_DIV  = 19440;
  localparam int          OC1_FRAME_DIV  = 6480;

endpackage

/* design/edge_divider.sv */
// divides a stream of source clock edges into a toggling output clock
`timescale 1ns/10ps
module edge_divider
  import tx_clock_pkg::*;
(
  input  wire logic              mclk,      // system clock
  input  wire logic              rst_n,     // synchronised reset, active low
  input  wire logic              clr,       // restart the divider
  input  wire logic              edge_en,   // one-cycle pulse per source rising edge
  input  wire logic [HALF_W-1:0] half_cnt,  // source edges per half period
  output logic                   div_q      // divided clock level
);

  logic [HALF_W-1:0] cnt_q;
  logic [HALF_W-1:0] cnt_d;
  logic              div_d;

  // count edges and toggle each half period; a change of rate restarts cleanly
  always_comb begin
    cnt_d = cnt_q;
    div_d = div_q;
    if (clr) begin
      cnt_d = '0;
      div_d = 1'b0;
    end else if (edge_en) begin
      if (cnt_q >= half_cnt - 15'h0001) begin
        cnt_d = '0;
        div_d = ~div_q;
      end else begin
        cnt_d = cnt_q + 15'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      div_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      div_q <= div_d;
    end
  end

endmodule

/* design/quad_tx_serial_clock_select.sv */
// transmit clock selection and distribution for four serial line channels
//
// Notes on behaviour
// - serial data output of each channel changes only on its transmit clock rising edge
// - differential clock output is an undivided copy of the channel's transmit clock
// - a configuration bit floats the differential clock outputs
// - source select 01 receive clock, 10 own input, 11 shared input
// - line loopback forces the receive clock, overriding the source select
// - 155 Mbit/s single-ended clock is 77.76, 38.88, 19.44 MHz or 8 kHz
// - 51 Mbit/s single-ended clock is 51.84 to 6.48 MHz or 8 kHz
// - the shared clock input times each channel for which it is chosen
`timescale 1ns/10ps
module quad_tx_serial_clock_select
  import tx_clock_pkg::*;
#(
  parameter int OC3_FRAME_DIVISOR = OC3_FRAME_DIV, // edges per 8 kHz period at 155 Mbit/s
  parameter int OC1_FRAME_DIVISOR = OC1_FRAME_DIV  // edges per 8 kHz period at 51 Mbit/s
)
(
  input  wire logic                           mclk,                 // 40 MHz clock
  input  wire logic                           nrst,                 // async reset, active low
  input  wire logic [tx_clock_pkg::ADDR_W-1:0] reg_addr,            // register index
  input  wire logic [tx_clock_pkg::DATA_W-1:0] reg_wdata,           // write data
  input  wire logic                           reg_wr,               // write strobe
  input  wire logic                           reg_rd,               // read strobe
  output logic      [tx_clock_pkg::DATA_W-1:0] reg_rdata,           // read data, next cycle
  input  wire logic [tx_clock_pkg::NUM_CH-1:0] rx_serial_clock_in,  // per-channel receive clock
  input  wire logic [tx_clock_pkg::NUM_CH-1:0] channel_tx_clock_in, // per-channel tx clock
  input  wire logic                           shared_tx_clock_in,   // common tx clock
  input  wire logic [tx_clock_pkg::NUM_CH-1:0] tx_line_bit,         // next outgoing line bit
  output logic      [tx_clock_pkg::NUM_CH-1:0] tx_bit_taken,        // pulse: line bit launched
  output logic      [tx_clock_pkg::NUM_CH-1:0] serial_tx_data_out_p, // serial data, true
  output logic      [tx_clock_pkg::NUM_CH-1:0] serial_tx_data_out_n, // serial data, inverted
  output logic      [tx_clock_pkg::NUM_CH-1:0] diff_tx_clock_out_p, // forwarded clock, true
  output logic      [tx_clock_pkg::NUM_CH-1:0] diff_tx_clock_out_n, // forwarded clock, inverted
  output logic      [tx_clock_pkg::NUM_CH-1:0] diff_tx_clock_out_oe, // high while driven
  output logic      [tx_clock_pkg::NUM_CH-1:0] single_ended_tx_clock_out // divided clock
);

  // reset release through two flops; assertion stays asynchronous
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // configuration registers
  logic [DATA_W-1:0] tx_clock_config_reg_q;
  logic [DATA_W-1:0] tx_clock_config_reg_d;
  logic [DATA_W-1:0] clock_output_config_reg_q;
  logic [DATA_W-1:0] clock_output_config_reg_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] status_word;
  logic [NUM_CH*SRC_SEL_W-1:0] eff_src_all;
  logic              diff_clock_out_tristate;

  assign diff_clock_out_tristate = tx_clock_config_reg_q[TRISTATE_BIT];

  // status shows the source each channel really runs on
  always_comb begin
    status_word = '0;
    status_word[EFF_SRC_LSB +: NUM_CH*SRC_SEL_W] = eff_src_all;
    status_word[LB_STAT_LSB +: NUM_CH] = tx_clock_config_reg_q[LOOPBACK_LSB +: NUM_CH];
  end

  // register writes and reads; read data stand for one cycle only, unmapped reads zero
  always_comb begin
    tx_clock_config_reg_d     = tx_clock_config_reg_q;
    clock_output_config_reg_d = clock_output_config_reg_q;
    rdata_d                   = '0;
    if (reg_wr) begin
      case (reg_addr)
        TX_CLOCK_CONFIG_ADDR:  tx_clock_config_reg_d = reg_wdata & 16'h1fff;
        CLOCK_OUT_CONFIG_ADDR: clock_output_config_reg_d = reg_wdata;
        default:               tx_clock_config_reg_d = tx_clock_config_reg_q;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        TX_CLOCK_CONFIG_ADDR:  rdata_d = tx_clock_config_reg_q;
        CLOCK_OUT_CONFIG_ADDR: rdata_d = clock_output_config_reg_q;
        CLOCK_STATUS_ADDR:     rdata_d = status_word;
        default:               rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_clock_config_reg_q     <= TX_CLOCK_CONFIG_RST;
      clock_output_config_reg_q <= CLOCK_OUT_CONFIG_RST;
      rdata_q                   <= '0;
    end else begin
      tx_clock_config_reg_q     <= tx_clock_config_reg_d;
      clock_output_config_reg_q <= clock_output_config_reg_d;
      rdata_q                   <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // the 8 kHz half periods are fixed by the parameters
  localparam logic [HALF_W-1:0] HALF_OC3_FRAME = HALF_W'(OC3_FRAME_DIVISOR / 2);
  localparam logic [HALF_W-1:0] HALF_OC1_FRAME = HALF_W'(OC1_FRAME_DIVISOR / 2);

  // one identical slice per channel
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [1:0]        sel_field;
    logic              loopback;
    logic [2:0]        rate;
    logic              oc1_mode;
    logic [1:0]        eff_src;
    logic              src_lvl;
    logic              pass_through;
    logic [HALF_W-1:0] half_cnt;
    logic              div_lvl;
    logic              clk_lvl_q;
    logic              clk_lvl_d;
    logic              clk_prev_q;
    logic              rise;
    logic              data_q;
    logic              data_d;
    logic              data_n_q;
    logic              data_n_d;
    logic              fwd_n_q;
    logic              fwd_n_d;
    logic              taken_q;
    logic              taken_d;
    logic              fwd_q;
    logic              fwd_d;
    logic              oe_q;
    logic              oe_d;
    logic              se_q;
    logic              se_d;
    logic [3:0]        rate_cfg_q;
    logic              rate_chg;

    assign sel_field = tx_clock_config_reg_q[SRC_SEL_LSB + SRC_SEL_W*ch +: SRC_SEL_W];
    assign loopback  = tx_clock_config_reg_q[LOOPBACK_LSB + ch];
    assign rate      = clock_output_config_reg_q[RATE_LSB + RATE_W*ch +: RATE_W];
    assign oc1_mode  = clock_output_config_reg_q[OC1_MODE_LSB + ch];

    // loopback overrides the select; the reserved code falls back to the own input
    always_comb begin
      if (loopback) begin
        eff_src = SRC_RX_CLOCK;
      end else if (sel_field == SRC_RESERVED) begin
        eff_src = SRC_OWN_CLOCK;
      end else begin
        eff_src = sel_field;
      end
    end

    assign eff_src_all[SRC_SEL_W*ch +: SRC_SEL_W] = eff_src;

    // clock source multiplexer
    always_comb begin
      case (eff_src)
        SRC_RX_CLOCK:  src_lvl = rx_serial_clock_in[ch];
        SRC_SHARED:    src_lvl = shared_tx_clock_in;
        default:       src_lvl = channel_tx_clock_in[ch];
      endcase
    end

    // rate decode for the single-ended output; out-of-range codes give 8 kHz
    always_comb begin
      pass_through = 1'b0;
      if (oc1_mode) begin
        case (rate)
          RATE_CODE_0: begin
            half_cnt     = HALF_DIV2;
            pass_through = 1'b1;
          end
          RATE_CODE_1: half_cnt = HALF_DIV2;
          RATE_CODE_2: half_cnt = HALF_DIV4;
          RATE_CODE_3: half_cnt = HALF_DIV8;
          default:     half_cnt = HALF_OC1_FRAME;
        endcase
      end else begin
        case (rate)
          RATE_CODE_0: half_cnt = HALF_DIV2;
          RATE_CODE_1: half_cnt = HALF_DIV4;
          RATE_CODE_2: half_cnt = HALF_DIV8;
          default:     half_cnt = HALF_OC3_FRAME;
        endcase
      end
    end

    // the divider restarts whenever rate or mode changes, avoiding a runt phase
    assign rate_chg = rate_cfg_q != {oc1_mode, rate};
    assign rise     = clk_lvl_q & ~clk_prev_q;

    // next values of the channel outputs; the clock is sampled once, then fanned out
    always_comb begin
      clk_lvl_d = src_lvl;
      data_d    = data_q;
      taken_d   = 1'b0;
      if (rise) begin
        data_d  = tx_line_bit[ch];
        taken_d = 1'b1;
      end
      fwd_d = clk_lvl_q;
      // complements get flops of their own so every pin leaves a register
      data_n_d = ~data_d;
      fwd_n_d  = ~clk_lvl_q;
      oe_d  = ~diff_clock_out_tristate;
      se_d  = pass_through ? clk_lvl_q : div_lvl;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        clk_lvl_q  <= 1'b0;
        clk_prev_q <= 1'b0;
        data_q     <= 1'b0;
        data_n_q   <= 1'b1;
        taken_q    <= 1'b0;
        fwd_q      <= 1'b0;
        fwd_n_q    <= 1'b1;
        oe_q       <= 1'b0;
        se_q       <= 1'b0;
        rate_cfg_q <= 4'h0;
      end else begin
        clk_lvl_q  <= clk_lvl_d;
        clk_prev_q <= clk_lvl_q;
        data_q     <= data_d;
        data_n_q   <= data_n_d;
        taken_q    <= taken_d;
        fwd_q      <= fwd_d;
        fwd_n_q    <= fwd_n_d;
        oe_q       <= oe_d;
        se_q       <= se_d;
        rate_cfg_q <= {oc1_mode, rate};
      end
    end

    edge_divider u_div (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .clr      (rate_chg),
      .edge_en  (rise),
      .half_cnt (half_cnt),
      .div_q    (div_lvl)
    );

    // pin drivers, all straight from flops
    assign serial_tx_data_out_p[ch]      = data_q;
    assign serial_tx_data_out_n[ch]      = data_n_q;
    assign diff_tx_clock_out_p[ch]       = fwd_q;
    assign diff_tx_clock_out_n[ch]       = fwd_n_q;
    assign diff_tx_clock_out_oe[ch]      = oe_q;
    assign single_ended_tx_clock_out[ch] = se_q;
    assign tx_bit_taken[ch]              = taken_q;
  end

endmodule

/* sim/line_clock_source.sv */
// behavioural line-side clock sources facing the transmit clock selector
`timescale 1ns/10ps
module line_clock_source
  import tx_clock_pkg::*;
(
  input  wire logic              mclk,                // bench clock
  input  wire logic              slow,                // doubles every half period
  output logic      [NUM_CH-1:0] rx_serial_clock_in,  // recovered receive clocks
  output logic      [NUM_CH-1:0] channel_tx_clock_in, // per-channel transmit clocks
  output logic                   shared_tx_clock_in   // common transmit clock
);
  int cnt = 0;
  int m;
  // equal high and low times, distinct periods so a wrong source shows up
  always @(posedge mclk) begin
    cnt <= cnt + 1;
    m = slow ? 2 : 1;
    for (int i = 0; i < NUM_CH; i++) begin
      rx_serial_clock_in[i]  <= ((cnt + i) / (3 * m)) % 2;
      channel_tx_clock_in[i] <= ((cnt + i) / (4 * m)) % 2;
    end
    shared_tx_clock_in <= (cnt / (5 * m)) % 2;
  end
endmodule

/* sim/quad_tx_serial_clock_select_checker.sv */
// port-level assertions for the quad transmit clock selector
`timescale 1ns/10ps
module quad_tx_serial_clock_select_checker
  import tx_clock_pkg::*;
#(
  parameter int OC3_FRAME_DIVISOR = OC3_FRAME_DIV, // edges per 8 kHz period, 155 mode
  parameter int OC1_FRAME_DIVISOR = OC1_FRAME_DIV  // edges per 8 kHz period, 51 mode
)
(
  input wire logic              mclk,                      // clock
  input wire logic              nrst,                      // reset, active low
  input wire logic [ADDR_W-1:0] reg_addr,                  // register index
  input wire logic [DATA_W-1:0] reg_wdata,                 // write data
  input wire logic              reg_wr,                    // write strobe
  input wire logic              reg_rd,                    // read strobe
  input wire logic [DATA_W-1:0] reg_rdata,                 // read data
  input wire logic [NUM_CH-1:0] rx_serial_clock_in,        // receive clocks
  input wire logic [NUM_CH-1:0] channel_tx_clock_in,       // own clocks
  input wire logic              shared_tx_clock_in,        // common clock
  input wire logic [NUM_CH-1:0] tx_line_bit,               // line bits
  input wire logic [NUM_CH-1:0] tx_bit_taken,              // launch pulses
  input wire logic [NUM_CH-1:0] serial_tx_data_out_p,      // data, true
  input wire logic [NUM_CH-1:0] serial_tx_data_out_n,      // data, inverted
  input wire logic [NUM_CH-1:0] diff_tx_clock_out_p,       // clock, true
  input wire logic [NUM_CH-1:0] diff_tx_clock_out_n,       // clock, inverted
  input wire logic [NUM_CH-1:0] diff_tx_clock_out_oe,      // clock driven
  input wire logic [NUM_CH-1:0] single_ended_tx_clock_out  // divided clock
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [15:0]       cfg_q, cfg_d;   // shadow of the transmit clock config
  logic [3:0]        calm_q, calm_d; // cycles since last config write, saturating
  logic [NUM_CH-1:0] sel;            // level each forwarded clock should copy
  logic [11:0]       stat;           // expected status bits
  logic [1:0]        src;
  // shadow follows writes so the checks know which source is live
  always_comb begin
    cfg_d = cfg_q;
    calm_d = (calm_q == 4'hf) ? calm_q : calm_q + 4'h1;
    if (reg_wr && reg_addr == TX_CLOCK_CONFIG_ADDR) begin
      cfg_d = {3'h0, reg_wdata[12:0]};
      calm_d = 4'h0;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      src = cfg_q[LOOPBACK_LSB+i] ? SRC_RX_CLOCK : cfg_q[2*i +: 2];
      if (src == SRC_RESERVED) src = SRC_OWN_CLOCK;
      stat[2*i +: 2] = src;
      stat[LB_STAT_LSB+i] = cfg_q[LOOPBACK_LSB+i];
      sel[i] = (src == SRC_RX_CLOCK) ? rx_serial_clock_in[i] :
               (src == SRC_SHARED) ? shared_tx_clock_in : channel_tx_clock_in[i];
    end
  end
  // registered shadow
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= TX_CLOCK_CONFIG_RST;
      calm_q <= 4'h0;
    end else begin
      cfg_q <= cfg_d;
      calm_q <= calm_d;
    end
  end
  sequence read_status_s; reg_rd && reg_addr == CLOCK_STATUS_ADDR; endsequence
  sequence read_config_s; reg_rd && reg_addr == TX_CLOCK_CONFIG_ADDR; endsequence
  data_pair_a: assert property (
    serial_tx_data_out_n == ~serial_tx_data_out_p) else $error("data pair not inverse");
  clock_pair_a: assert property (
    diff_tx_clock_out_n == ~diff_tx_clock_out_p) else $error("clock pair not inverse");
  data_on_rise_a: assert property (
    ((serial_tx_data_out_p ^ $past(serial_tx_data_out_p)) & ~tx_bit_taken) == '0)
    else $error("data changed without a clock rise");
  taken_with_clock_a: assert property (
    (tx_bit_taken & ~(diff_tx_clock_out_p & ~$past(diff_tx_clock_out_p))) == '0)
    else $error("bit launched without forwarded clock rise");
  taken_pulse_a: assert property ((tx_bit_taken & $past(tx_bit_taken)) == '0)
    else $error("launch pulse longer than one cycle");
  clock_follow_a: assert property (
    calm_q > 4'h5 && (&diff_tx_clock_out_oe) |-> diff_tx_clock_out_p == $past(sel, 2))
    else $error("forwarded clock not the selected source");
  status_read_a: assert property (
    read_status_s |=> reg_rdata == {4'h0, $past(stat)}) else $error("status mismatch");
  config_read_a: assert property (
    read_config_s |=> reg_rdata == $past(cfg_q)) else $error("config readback mismatch");
  float_clock_a: assert property (cfg_q[TRISTATE_BIT] [*3] |-> diff_tx_clock_out_oe == '0)
    else $error("clock driven while floated");
  drive_clock_a: assert property (
    !cfg_q[TRISTATE_BIT] && calm_q > 4'h7 |-> diff_tx_clock_out_oe == '1)
    else $error("clock not driven");
  idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read cycle");
endmodule
bind quad_tx_serial_clock_select quad_tx_serial_clock_select_checker #(
  .OC3_FRAME_DIVISOR(OC3_FRAME_DIVISOR), .OC1_FRAME_DIVISOR(OC1_FRAME_DIVISOR)) chk_i (
  .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_serial_clock_in,
  .channel_tx_clock_in, .shared_tx_clock_in, .tx_line_bit, .tx_bit_taken,
  .serial_tx_data_out_p, .serial_tx_data_out_n, .diff_tx_clock_out_p,
  .diff_tx_clock_out_n, .diff_tx_clock_out_oe, .single_ended_tx_clock_out);

/* sim/tb_quad_tx_serial_clock_select.sv */
// self-checking bench for the quad transmit clock selector
`timescale 1ns/10ps
module tb_quad_tx_serial_clock_select;
  import tx_clock_pkg::*;
  logic              mclk, nrst, reg_wr, reg_rd, slow, shared_tx_clock_in;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, cfg_m;
  logic [DATA_W-1:0] seed = 16'h0015;
  logic [NUM_CH-1:0] tx_line_bit = '0;
  logic [NUM_CH-1:0] rx_serial_clock_in, channel_tx_clock_in, tx_bit_taken;
  logic [NUM_CH-1:0] serial_tx_data_out_p, serial_tx_data_out_n, diff_tx_clock_out_p;
  logic [NUM_CH-1:0] diff_tx_clock_out_n, diff_tx_clock_out_oe, single_ended_tx_clock_out;
  int                errors = 0, total_checks = 0, cyc = 0;
  int                dv[2][5] = '{'{2, 4, 8, 16, 16}, '{1, 2, 4, 8, 12}};
  quad_tx_serial_clock_select #(.OC3_FRAME_DIVISOR(16), .OC1_FRAME_DIVISOR(12))
    quad_tx_serial_clock_select_i (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_serial_clock_in, .channel_tx_clock_in, .shared_tx_clock_in,
    .tx_line_bit, .tx_bit_taken, .serial_tx_data_out_p, .serial_tx_data_out_n,
    .diff_tx_clock_out_p, .diff_tx_clock_out_n, .diff_tx_clock_out_oe,
    .single_ended_tx_clock_out);
  line_clock_source line_clock_source_i (.mclk, .slow, .rx_serial_clock_in,
    .channel_tx_clock_in, .shared_tx_clock_in);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected status from the model of the config register
  function automatic logic [15:0] stat_m();
    logic [15:0] s;
    logic [1:0]  c;
    s = {4'h0, cfg_m[11:8], 8'h00};
    for (int i = 0; i < NUM_CH; i++) begin
      c = cfg_m[LOOPBACK_LSB+i] ? SRC_RX_CLOCK : cfg_m[2*i +: 2];
      s[2*i +: 2] = (c == SRC_RESERVED) ? SRC_OWN_CLOCK : c;
    end
    return s;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (a == TX_CLOCK_CONFIG_ADDR) cfg_m = {3'h0, d[12:0]};
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask
  // counts divided-clock rises over 96 launched bits of channel 0
  task automatic rate(input int div);
    int  n, r;
    logic p;
    n = 0;
    r = 0;
    p = single_ended_tx_clock_out[0];
    while (n < 96) begin
      @(posedge mclk);
      #1;
      n += (tx_bit_taken[0] === 1'b1);
      r += (single_ended_tx_clock_out[0] === 1'b1 && p === 1'b0);
      p = single_ended_tx_clock_out[0];
    end
    chk("se_rises", 96 / div, (r >= 96 / div - 1 && r <= 96 / div + 1) ? 96 / div : r);
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // the line model: each launched bit must be the one offered, then a fresh one
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      summarize();
    end
    for (int i = 0; i < NUM_CH; i++) if (nrst && tx_bit_taken[i] === 1'b1) begin
      chk("serial_tx_data_out_p", {15'h0, tx_line_bit[i]}, {15'h0, serial_tx_data_out_p[i]});
      seed = lfsr(seed);
      tx_line_bit[i] <= seed[0];
    end
  end
  initial begin
    {nrst, reg_wr, reg_rd, slow, reg_addr, reg_wdata} = '0;
    cfg_m = TX_CLOCK_CONFIG_RST;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(TX_CLOCK_CONFIG_ADDR, 16'h00aa);
    rd(CLOCK_OUT_CONFIG_ADDR, 16'h0000);
    rd(4'h7, 16'h0000);
    wr(4'h9, 16'hffff);
    rd(TX_CLOCK_CONFIG_ADDR, 16'h00aa);
    for (int c = 0; c < 4; c++) for (int lb = 0; lb < 2; lb++) begin
      wr(TX_CLOCK_CONFIG_ADDR, {4'h0, lb ? 4'h5 : 4'h0, {4{c[1:0]}}});
      repeat (60) @(posedge mclk);
      rd(TX_CLOCK_CONFIG_ADDR, cfg_m);
      rd(CLOCK_STATUS_ADDR, stat_m());
    end
    wr(TX_CLOCK_CONFIG_ADDR, 16'hf0aa);
    repeat (6) @(posedge mclk);
    #1;
    chk("diff_tx_clock_out_oe", 16'h0000, {12'h0, diff_tx_clock_out_oe});
    rd(TX_CLOCK_CONFIG_ADDR, cfg_m);
    wr(TX_CLOCK_CONFIG_ADDR, 16'h00aa);
    repeat (10) @(posedge mclk);
    #1;
    chk("diff_tx_clock_out_oe", 16'h000f, {12'h0, diff_tx_clock_out_oe});
    // the last pass of each mode uses code 7 so the out-of-range 8 kHz decode is reached
    for (int md = 0; md < 2; md++) for (int c = 0; c < 5; c++) begin
      slow <= md[0];
      wr(CLOCK_OUT_CONFIG_ADDR, {md ? 4'hf : 4'h0, {4{c == 4 ? 3'h7 : c[2:0]}}});
      rd(CLOCK_OUT_CONFIG_ADDR, {md ? 4'hf : 4'h0, {4{c == 4 ? 3'h7 : c[2:0]}}});
      rate(dv[md][c]);
    end
    summarize();
  end
endmodule
